// ---- core/icgst_regs.vh ----
// Register offsets, field positions, reset values and timing counts for the clock generator control block
`ifndef ICGST_REGS_VH
`define ICGST_REGS_VH
`define ICGST_OFF_CTRL 8'h00
`define ICGST_OFF_STAT 8'h04
`define ICGST_OFF_MULT 8'h08
`define ICGST_OFF_TRIM 8'h0c
`define ICGST_OFF_CFG 8'h10
`define ICGST_OFF_IRQ_STAT 8'h14
`define ICGST_OFF_IRQ_MASK 8'h18
`define ICGST_OFF_FILT 8'h1c
`define ICGST_CTRL_ECG_EN 0
`define ICGST_CTRL_ICG_EN 1
`define ICGST_CTRL_CLK_SEL 2
`define ICGST_CTRL_MON_EN 3
`define ICGST_CTRL_MON_IE 4
`define ICGST_CTRL_STOP 5
`define ICGST_CTRL_WAIT 6
`define ICGST_STAT_ISTABLE 0
`define ICGST_STAT_ESTABLE 1
`define ICGST_STAT_MONFLAG 2
`define ICGST_STAT_XTAL_DRV 3
`define ICGST_STAT_OSC1_FUNC 4
`define ICGST_STAT_CLK_RUN 5
`define ICGST_CFG_EXT 0
`define ICGST_CFG_XTAL 1
`define ICGST_CFG_SLOW 2
`define ICGST_CFG_STOPOSC 3
`define ICGST_IRQ_ISTABLE 0
`define ICGST_IRQ_ESTABLE 1
`define ICGST_IRQ_MONFLAG 2
`define ICGST_IRQ_SETTLED 3
`define ICGST_MULT_RESET 7'h15
`define ICGST_TRIM_RESET 8'h80
`define ICGST_CFG_RESET 4'h0
`define ICGST_CAP_FIXED 10'h180
`define ICGST_CAP_TOTAL 10'h27f
`define ICGST_CORR_PERIODS 4
`define ICGST_FINE_CORR_MAX 24
`define ICGST_TOTAL_CORR_MAX 32
`define ICGST_TOTAL_BASE_PERIODS 128
`define ICGST_XTAL_STAB_CYCLES 4096
`define ICGST_EXT_STAB_CYCLES 16
`define ICGST_CLK_HZ 100000000
`define ICGST_BASE_HZ 307200
`define ICGST_BASE_DIV ((`ICGST_CLK_HZ + `ICGST_BASE_HZ - 1) / `ICGST_BASE_HZ)
`define ICGST_MON_XTAL_LO_HZ 30000
`define ICGST_MON_XTAL_MID_LO_HZ 100000
`define ICGST_MON_XTAL_MID_HI_HZ 1000000
`define ICGST_MON_ANY_LO_HZ 60
`define ICGST_MON_HI_HZ 32000000
`define ICGST_MON_SLOW_HI_HZ 307200
`endif

// ---- core/icgst_base_div.v ----
// Divider producing the base-clock enable pulse from the system clock
module icgst_base_div #(
	parameter DIV = 326
) (
	input wire clk, // System clock
	input wire rst_b, // Async reset, active low
	input wire run, // Divider runs while high
	output reg tick // One-cycle base-clock pulse
);
	reg [15:0] cnt;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (!run) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == DIV[15:0] - 16'h0001) begin
			cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // icgst_base_div

// ---- core/icgst_stab_div.v ----
// External clock stabilization divider with selectable timeout
module icgst_stab_div #(
	parameter LONG = 4096,
	parameter SHORT = 16
) (
	input wire clk, // System clock
	input wire rst_b, // Async reset, active low
	input wire arm, // Restart count while high
	input wire ext_edge, // One external clock cycle seen
	input wire long_sel, // Crystal timeout selected
	output reg done // Timeout reached
);
	reg [12:0] cnt;
	wire [12:0] limit = long_sel ? LONG[12:0] : SHORT[12:0];
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 13'h0000;
			done <= 1'b0;
		end else if (arm) begin
			cnt <= 13'h0000;
			done <= 1'b0;
		end else if (ext_edge && !done) begin
			cnt <= cnt + 13'h0001;
			if (cnt + 13'h0001 >= limit) begin
				done <= 1'b1;
			end
		end
	end
endmodule // icgst_stab_div

// ---- core/icgst_top.v ----
// Clock generator settling, trim, low-power and option control with AXI4-Lite registers
`include "icgst_regs.vh"

// Summary of operation
// - Fine phase: minimum steps, four periods, max 24
// - From fifteen percent: max 32 corrections, 128 periods
// - Capacitor: 384 fixed plus trim units, 639
// - Trim resets to 128, capacitor 512
// - Each trim unit shifts base frequency 0.195%
// - Runs in wait; enabled interrupt wakes
// - Stop without option: all clocks held low
// - Stop with option: clocks run, no wake
// - Stop without option clears stables, monitor bits
// - Stop leaves select, generator enables, multiplier, trim alone
// - External enable settable only with external option
// - Crystal amplifier needs crystal, external, enable set
// - Monitor valid range follows crystal option
// - Stabilization timeout 4096 crystal, else 16
// - Slow option: monitor expects slower external clock
// - All four options reset clear
// - Multiplier or trim write clears internal stable
module icgst_top #(
	parameter XTAL_STAB = `ICGST_XTAL_STAB_CYCLES,
	parameter EXT_STAB = `ICGST_EXT_STAB_CYCLES,
	parameter BASE_DIV = `ICGST_BASE_DIV,
	parameter FINE_MAX = `ICGST_FINE_CORR_MAX,
	parameter TOTAL_MAX = `ICGST_TOTAL_CORR_MAX
) (
	input wire clk, // System clock
	input wire rst_b, // Async reset, active low
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire ext_clk_edge, // One external clock cycle, pulse
	input wire ext_clk_active, // Monitor sees external clock
	input wire int_clk_active, // Monitor sees internal clock
	input wire freq_err_fine, // Period error below five percent
	input wire freq_err_sign, // Clock too fast when high
	output reg [9:0] cap_units, // Connected capacitor units
	output reg [4:0] fine_step, // Fine stage control field
	output reg correct_pulse, // One correction applied
	output wire oscillator_output_clock_en, // Oscillator output clock gate
	output wire module_output_clock_en, // Module output clock gate
	output wire timebase_clock_en, // Timebase clock gate
	output wire osc1_clk_func, // Oscillator input pin as clock
	output wire osc2_drive_n, // Second pin driven when low
	output wire [1:0] mon_range, // Monitor expected range code
	output wire wake_req, // Wake from wait
	output wire irq // Interrupt, level
);
	reg [6:0] multiplier_reg;
	reg [7:0] trim_reg;
	reg [3:0] cfg;
	reg external_generator_enable, internal_generator_enable, clk_sel;
	reg monitor_enable, monitor_interrupt_enable, monitor_flag;
	reg internal_stable_flag, stop_req, wait_req;
	reg [3:0] irq_stat, irq_mask;
	reg [5:0] corr_cnt;
	reg [1:0] per_cnt;
	reg settled;
	reg [4:0] fine_cnt;
	reg [3:0] ev_prev;
	reg aw_held, w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire base_tick, ext_stable;
	// Last base period of each correction window
	localparam integer CORR_LAST = `ICGST_CORR_PERIODS - 1;

	wire external_clock_option = cfg[`ICGST_CFG_EXT];
	wire crystal_option = cfg[`ICGST_CFG_XTAL];
	wire slow_clock_option = cfg[`ICGST_CFG_SLOW];
	wire stop_oscillator_option = cfg[`ICGST_CFG_STOPOSC];
	wire dead_stop = stop_req && !stop_oscillator_option;
	wire clk_run = !dead_stop && internal_generator_enable;

	// A held channel refuses more until its response is taken
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire aw_ok = aw_held || (s_axi_awvalid && s_axi_awready);
	wire w_ok = w_held || (s_axi_wvalid && s_axi_wready);
	wire wr_go = aw_ok && w_ok;
	wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wd = w_held ? w_data : s_axi_wdata;
	wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
	wire wr_b0 = wr_go && ws[0];

	// Address decode shared by every register strobe
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'b00) && (a <= `ICGST_OFF_FILT);
		end
	endfunction

	wire wr_ctrl = wr_b0 && hit(wa, `ICGST_OFF_CTRL);
	wire wr_mult = wr_b0 && hit(wa, `ICGST_OFF_MULT);
	wire wr_trim = wr_b0 && hit(wa, `ICGST_OFF_TRIM);
	wire wr_cfg = wr_b0 && hit(wa, `ICGST_OFF_CFG);
	wire wr_istat = wr_b0 && hit(wa, `ICGST_OFF_IRQ_STAT);
	wire wr_imask = wr_b0 && hit(wa, `ICGST_OFF_IRQ_MASK);

	icgst_base_div #(
		.DIV(BASE_DIV)
	) u_base (
		.clk(clk),
		.rst_b(rst_b),
		.run(clk_run),
		.tick(base_tick)
	);

	icgst_stab_div #(
		.LONG(XTAL_STAB),
		.SHORT(EXT_STAB)
	) u_stab (
		.clk(clk),
		.rst_b(rst_b),
		.arm(!external_generator_enable || dead_stop || (monitor_enable && !ext_clk_active)),
		.ext_edge(ext_clk_edge),
		.long_sel(crystal_option),
		.done(ext_stable)
	);

	// Write channel capture, either order
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wa) ? 2'b00 : 2'b10;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// Read channel
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
			case (s_axi_araddr)
				`ICGST_OFF_CTRL: s_axi_rdata <= {25'h0, wait_req, stop_req, monitor_interrupt_enable,
					monitor_enable, clk_sel, internal_generator_enable, external_generator_enable};
				`ICGST_OFF_STAT: s_axi_rdata <= {26'h0, clk_run, osc1_clk_func, !osc2_drive_n,
					monitor_flag, ext_stable, internal_stable_flag};
				`ICGST_OFF_MULT: s_axi_rdata <= {25'h0, multiplier_reg};
				`ICGST_OFF_TRIM: s_axi_rdata <= {24'h0, trim_reg};
				`ICGST_OFF_CFG: s_axi_rdata <= {28'h0, cfg};
				`ICGST_OFF_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
				`ICGST_OFF_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
				`ICGST_OFF_FILT: s_axi_rdata <= {16'h0, settled, 1'b0, corr_cnt, 3'h0, fine_step};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control bits and their interlocks
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= `ICGST_CFG_RESET;
			multiplier_reg <= `ICGST_MULT_RESET;
			trim_reg <= `ICGST_TRIM_RESET;
			external_generator_enable <= 1'b0;
			internal_generator_enable <= 1'b1;
			clk_sel <= 1'b0;
			monitor_enable <= 1'b0;
			monitor_interrupt_enable <= 1'b0;
			monitor_flag <= 1'b0;
			stop_req <= 1'b0;
			wait_req <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg <= wd[3:0];
			end
			// Multiplier, trim, select and generator enables are kept through stop
			if (wr_mult) begin
				multiplier_reg <= wd[6:0];
			end
			if (wr_trim) begin
				trim_reg <= wd[7:0];
			end
			if (wr_ctrl) begin
				stop_req <= wd[`ICGST_CTRL_STOP];
				wait_req <= wd[`ICGST_CTRL_WAIT];
				external_generator_enable <= wd[`ICGST_CTRL_ECG_EN] && external_clock_option;
				internal_generator_enable <= wd[`ICGST_CTRL_ICG_EN] || !wd[`ICGST_CTRL_CLK_SEL];
				clk_sel <= wd[`ICGST_CTRL_CLK_SEL] && wd[`ICGST_CTRL_ECG_EN] && external_clock_option;
				monitor_enable <= wd[`ICGST_CTRL_MON_EN] && internal_stable_flag && ext_stable;
				monitor_interrupt_enable <= wd[`ICGST_CTRL_MON_IE] && monitor_enable;
			end else if (wake_req) begin
				wait_req <= 1'b0;
			end
			if (!external_clock_option) begin
				external_generator_enable <= 1'b0;
				clk_sel <= 1'b0;
			end
			if (monitor_enable && (!ext_clk_active || !int_clk_active)) begin
				monitor_flag <= 1'b1;
			end else if (wr_istat && wd[`ICGST_IRQ_MONFLAG]) begin
				monitor_flag <= 1'b0;
			end
			if (dead_stop) begin
				monitor_enable <= 1'b0;
				monitor_interrupt_enable <= 1'b0;
				monitor_flag <= 1'b0;
			end
		end
	end

	// Fine loop filter: one correction per four base periods
	// Any restart condition drops the counts so settling starts over
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			per_cnt <= 2'h0;
			corr_cnt <= 6'h00;
			fine_cnt <= 5'h00;
			fine_step <= 5'h10;
			correct_pulse <= 1'b0;
			settled <= 1'b0;
			internal_stable_flag <= 1'b0;
		end else begin
			correct_pulse <= 1'b0;
			if (wr_mult || wr_trim || dead_stop || !internal_generator_enable ||
				(monitor_enable && !int_clk_active)) begin
				per_cnt <= 2'h0;
				corr_cnt <= 6'h00;
				fine_cnt <= 5'h00;
				settled <= 1'b0;
				internal_stable_flag <= 1'b0;
			end else if (base_tick) begin
				per_cnt <= per_cnt + 2'h1;
				if (per_cnt == CORR_LAST[1:0]) begin
					if (corr_cnt < TOTAL_MAX[5:0]) begin
						corr_cnt <= corr_cnt + 6'h01;
					end
					if (freq_err_fine) begin
						internal_stable_flag <= 1'b1;
					end
					// Minimum steps only inside the fine window, bounded in number
					if (freq_err_fine && !settled && fine_cnt < FINE_MAX[4:0]) begin
						correct_pulse <= 1'b1;
						fine_cnt <= fine_cnt + 5'h01;
						fine_step <= freq_err_sign ? fine_step + 5'h01 : fine_step - 5'h01;
					end
					if (corr_cnt + 6'h01 >= TOTAL_MAX[5:0]) begin
						settled <= 1'b1;
					end
				end
			end
		end
	end

	// Capacitor: fixed units plus trim units
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_units <= `ICGST_CAP_FIXED + 10'h080;
		end else begin
			cap_units <= `ICGST_CAP_FIXED + {2'b00, trim_reg};
		end
	end

	// Interrupt status, sticky, set wins over clear
	// Sources are levels; only their rising edge sets a status bit,
	// so a clear sticks while the source stays high
	wire [3:0] ev = {settled, monitor_flag, ext_stable, internal_stable_flag};
	wire [3:0] ev_rise = ev & ~ev_prev;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			ev_prev <= 4'h0;
		end else begin
			ev_prev <= ev;
			irq_stat <= (irq_stat & ~((wr_istat) ? wd[3:0] : 4'h0)) | ev_rise;
			if (wr_imask) begin
				irq_mask <= wd[3:0];
			end
		end
	end

	wire irq_raw = |(irq_stat & irq_mask) || (monitor_flag && monitor_interrupt_enable);
	assign irq = irq_raw;
	// Stop blocks wake; only a control register write may end stop
	assign wake_req = wait_req && irq_raw && !stop_req;
	assign oscillator_output_clock_en = !dead_stop;
	assign module_output_clock_en = !dead_stop;
	assign timebase_clock_en = !dead_stop;
	assign osc1_clk_func = external_clock_option && external_generator_enable;
	assign osc2_drive_n = !(crystal_option && external_clock_option && external_generator_enable);
	assign mon_range = {slow_clock_option, crystal_option};
endmodule // icgst_top

// ---- verif/icgst_props.sv ----
// Port-level assertions for the clock generator control block
module icgst_props (
	input wire clk, // Clock
	input wire rst_b, // Reset
	input wire s_axi_awready, // Aw ready
	input wire s_axi_bvalid, // B valid
	input wire [9:0] cap_units, // Capacitor
	input wire correct_pulse, // Correction
	input wire oscillator_output_clock_en, // Osc gate
	input wire module_output_clock_en, // Module gate
	input wire timebase_clock_en, // Timebase gate
	input wire osc1_clk_func, // Osc1 clock
	input wire osc2_drive_n, // Amplifier on
	input wire wake_req, // Wake
	input wire irq // Interrupt
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_cap_in_range: assert property (
		cap_units >= 10'h180 && cap_units <= 10'h27f) else $error("cap out of range");
	a_cap_after_reset: assert property (
		$rose(rst_b) |-> cap_units == 10'h200) else $error("cap reset wrong");
	a_gates_agree: assert property (
		oscillator_output_clock_en == module_output_clock_en && module_output_clock_en == timebase_clock_en)
		else $error("clock gates differ");
	a_stop_no_wake: assert property (
		!oscillator_output_clock_en |-> !wake_req) else $error("wake while stopped");
	a_amp_needs_ext: assert property (
		!osc2_drive_n |-> osc1_clk_func) else $error("amplifier without ext path");
	a_wake_from_irq: assert property (
		wake_req |-> irq) else $error("wake without interrupt");
	a_corr_spacing: assert property (
		correct_pulse |=> !correct_pulse [*8]) else $error("corrections too close");
	a_resp_blocks_aw: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("aw taken during response");
endmodule // icgst_props

bind icgst_top icgst_props u_props (.clk, .rst_b, .s_axi_awready, .s_axi_bvalid, .cap_units, .correct_pulse,
	.oscillator_output_clock_en, .module_output_clock_en, .timebase_clock_en, .osc1_clk_func,
	.osc2_drive_n, .wake_req, .irq);

// ---- verif/icgst_ext_src.sv ----
// External clock source and frequency comparator model
module icgst_ext_src (
	input wire clk, // System clock
	input wire run, // Pin is a clock input
	input wire fine, // Error inside five percent
	output reg ext_clk_edge = 1'b0, // One external cycle
	output wire ext_clk_active, // Source alive
	output wire freq_err_fine, // Fine window flag
	output reg freq_err_sign = 1'b0 // Error sign
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	assign ext_clk_active = run;
	assign freq_err_fine = fine;
	// Edge every fourth cycle, only while the path is enabled
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		ext_clk_edge <= run && ph == 2'h3;
		freq_err_sign <= ~freq_err_sign;
	end
endmodule // icgst_ext_src

// ---- verif/icgst_top_tb.sv ----
// Self-checking bench for the clock generator control block
module icgst_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rv;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, fine = 1'b0, bready = 1'b1, rready = 1'b1;
	logic [1:0] lresp;
	wire awready, wready, bvalid, arready, rvalid;
	wire [31:0] rdata;
	wire [1:0] bresp, rresp, mon_range;
	wire [9:0] cap;
	wire [4:0] fstep;
	wire oen, men, ten, osc1, osc2_n, wake, irq, ext_edge, act, ferr, fsign, cpulse;
	int fails = 0, total_checks = 0;

	icgst_top #(.XTAL_STAB(32), .BASE_DIV(4)) dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_clk_edge(ext_edge), .ext_clk_active(act), .int_clk_active(1'b1), .freq_err_fine(ferr),
		.freq_err_sign(fsign), .cap_units(cap), .fine_step(fstep), .correct_pulse(cpulse),
		.oscillator_output_clock_en(oen), .module_output_clock_en(men), .timebase_clock_en(ten),
		.osc1_clk_func(osc1), .osc2_drive_n(osc2_n), .mon_range(mon_range), .wake_req(wake), .irq(irq));
	icgst_ext_src src (.clk(clk), .run(osc1), .fine(fine), .ext_clk_edge(ext_edge), .ext_clk_active(act),
		.freq_err_fine(ferr), .freq_err_sign(fsign));

	always #5 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic lim(input int n);
		if (n >= 100) begin
			fails++;
			$display("[ERR] %0t wait timeout", $time);
			summarize();
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		lresp = bresp;
		lim(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		rv = rdata;
		lresp = rresp;
		lim(n);
	endtask

	task automatic t_reset;
		chk(cap, 10'h200);
		chk(fstep, 5'h10);
		chk({oen, men, ten}, 3'h7);
		rd(8'h08);
		chk(rv, 32'h15);
		rd(8'h0c);
		chk(rv, 32'h80);
		rd(8'h10);
		chk(rv, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_trim;
		wr(8'h0c, 32'h0);
		cyc(1);
		chk(cap, 10'h180);
		wr(8'h0c, 32'hff);
		cyc(1);
		chk(cap, 10'h27f);
		wr(8'h0c, 32'h81);
		cyc(1);
		chk(cap, 10'h201);
		wr(8'h0c, 32'h80);
		$display("trim test done");
	endtask
	task automatic t_opts;
		wr(8'h00, 32'h3);
		rd(8'h00);
		chk(rv[0], 1'b0);
		chk(osc1, 1'b0);
		wr(8'h10, 32'h3);
		wr(8'h00, 32'h3);
		chk({osc1, osc2_n, mon_range}, 4'b1001);
		cyc(80);
		rd(8'h04);
		chk(rv[1], 1'b0);
		cyc(80);
		rd(8'h04);
		chk(rv[1], 1'b1);
		wr(8'h10, 32'h5);
		chk({osc1, osc2_n, mon_range}, 4'b1110);
		wr(8'h10, 32'h1);
		$display("option test done");
	endtask
	task automatic wait_istable;
		int n = 0;
		do begin
			cyc(8);
			rd(8'h04);
			n++;
		end while (rv[0] !== 1'b1 && n < 100);
		lim(n);
	endtask
	task automatic t_settle;
		int k = 0;
		fine <= 1'b1;
		wait_istable();
		wr(8'h08, 32'h15);
		rd(8'h04);
		chk(rv[0], 1'b0);
		wait_istable();
		repeat (64) begin
			@(posedge clk);
			if (cpulse === 1'b1) k++;
		end
		chk(k, 4);
		wr(8'h18, 32'h0);
		chk(irq, 1'b0);
		wr(8'h18, 32'hf);
		chk(irq, 1'b1);
		wr(8'h00, 32'h43);
		chk(wake, 1'b1);
		wr(8'h14, 32'hf);
		chk({irq, wake}, 2'h0);
		$display("settle and irq test done");
	endtask
	task automatic t_stop;
		wr(8'h00, 32'h1b);
		wr(8'h00, 32'h1b);
		rd(8'h00);
		chk(rv[4:3], 2'h3);
		wr(8'h00, 32'h3b);
		chk({oen, men, ten, wake}, 4'h0);
		rd(8'h04);
		chk(rv[2:0], 3'h0);
		rd(8'h00);
		chk(rv[4:0], 5'h03);
		rd(8'h0c);
		chk(rv, 32'h80);
		wr(8'h00, 32'h3);
		chk({oen, men, ten}, 3'h7);
		cyc(150);
		wr(8'h10, 32'h9);
		wr(8'h00, 32'h63);
		chk({oen, men, ten, irq, wake}, 5'h1e);
		wr(8'h00, 32'h3);
		$display("stop test done");
	endtask
	task automatic t_bad;
		rd(8'h20);
		chk(rv, 32'h0);
		chk(lresp, 2'h2);
		wr(8'h22, 32'h1);
		chk(lresp, 2'h2);
		$display("unmapped test done");
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_trim();
		t_opts();
		t_settle();
		t_stop();
		t_bad();
		summarize();
	end
endmodule // icgst_top_tb
